/* include/drive_ctrl_defines.vh */
// Summary of operation
// [RL1] terminal with function code 15 locks parameters
// [RL2] modes 00/01 lock writes while lock input on
// [RL3] modes 02/03 lock writes regardless of input
// [RL4] mode 10 allows only run-changeable writes
// [RL5] code 31 terminal forces panel as source
// [RL6] code 51 terminal forces terminal block source
// [RL7] source change while driving cancels run, stops
// [RL8] partner drops the selected source's run command before restarting
// [RL9] code 11 terminal holds motor output off
// [RL10] coast release restarts after retry wait time
// [RL11] panel run source: no automatic restart
// [RL12] restart mode: zero, matching, active matching
// [RL13] matching falls back to zero below threshold
// [RL14] zero restart is immediate, ignores wait
// [RL15] matching restart resumes at measured frequency
// [RL16] active matching start frequency select
// [RL17] scan ramps down, then reaccelerates to shutoff
// [RL18] scan current limit 2.00 ct, 1.50 vt
// [RL19] rejected writes leave stored value unchanged
`ifndef DRIVE_CTRL_DEFINES_VH
`define DRIVE_CTRL_DEFINES_VH
// ****************************
// register offsets
// ****************************
`define A_LOCK_MODE 5'h00
`define A_FREQ_SRC 5'h01
`define A_RUN_SRC 5'h02
`define A_RESTART 5'h03
`define A_RETRY_WAIT 5'h04
`define A_THRESH 5'h05
`define A_SCAN_CUR 5'h06
`define A_SCAN_TC 5'h07
`define A_SCAN_START 5'h08
`define A_DUTY 5'h09
`define A_BASE_FREQ 5'h0a
`define A_MAX_FREQ 5'h0b
`define A_SET_FREQ 5'h0c
`define A_STATUS 5'h0d
`define A_OUT_FREQ 5'h0e
`define A_FSEL_BASE 5'h10
// ****************************
// codes and limits
// ****************************
`define LK_INPUT 8'h00
`define LK_INPUT_F 8'h01
`define LK_ALL 8'h02
`define LK_ALL_F 8'h03
`define LK_RUNCHG 8'h10
`define FN_COAST 8'h0b
`define FN_LOCK 8'h0f
`define FN_PANEL 8'h1f
`define FN_TERM 8'h33
`define SRC_SETREG 2'h0
`define SRC_TERM 2'h1
`define SRC_PANEL 2'h2
`define SRC_COMM 2'h3
`define RS_ZERO 2'h0
`define RS_MATCH 2'h1
`define RS_ACTIVE 2'h2
`define SS_SHUT 2'h0
`define SS_MAX 2'h1
`define SS_NEW 2'h2
`define RETRY_MIN 16'h0003
`define RETRY_MAX 16'h03e8
`define THRESH_MAX 16'h9c40
`define SCAN_CT_MAX 16'h00c8
`define SCAN_VT_MAX 16'h0096
// ****************************
// reset values and timing
// ****************************
`define RST_RETRY 16'h000a
`define RST_MAX_FREQ 16'h1770
`define RST_BASE_FREQ 16'h1388
`define RST_SCAN_CUR 16'h0064
`define RST_SCAN_TC 16'h0001
`define MCLK_PERIOD_NS 100
`define WAIT_UNIT_NS 100000000
`define WAIT_UNIT_CYC (`WAIT_UNIT_NS / `MCLK_PERIOD_NS)
`define RAMP_STEP_NS 100000
`define RAMP_STEP_CYC (`RAMP_STEP_NS / `MCLK_PERIOD_NS)
`endif

/* rtl/retry_timer.v */
`timescale 1ns/1ns
`default_nettype none
`include "drive_ctrl_defines.vh"
module retry_timer #(
	parameter UNIT_CYC = `WAIT_UNIT_CYC
) (
	input wire mclk,
	input wire rst,
	input wire start,
	input wire [15:0] waitUnits,
	output reg done
);
// ****************************
// prescaled wait counter
// ****************************
reg [31:0] preCnt_r;
reg [15:0] unitCnt_r;
reg busy_r;
always @(posedge mclk or posedge rst) begin
	if (rst) begin
		preCnt_r <= 32'h0000_0000;
		unitCnt_r <= 16'h0000;
		busy_r <= 1'b0;
		done <= 1'b0;
	end else if (start) begin
		preCnt_r <= 32'h0000_0000;
		unitCnt_r <= waitUnits;
		busy_r <= 1'b1;
		done <= 1'b0;
	end else if (busy_r) begin
		if (unitCnt_r == 16'h0000) begin
			busy_r <= 1'b0;
			done <= 1'b1;
		end else if (preCnt_r == UNIT_CYC - 1) begin
			preCnt_r <= 32'h0000_0000;
			unitCnt_r <= unitCnt_r - 16'h0001;
		end else begin
			preCnt_r <= preCnt_r + 32'h0000_0001;
		end
	end else begin
		done <= 1'b0;
	end
end
endmodule
`default_nettype wire

/* rtl/drive_ctrl.v */
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "drive_ctrl_defines.vh"
module drive_ctrl #(
	parameter WAIT_CYC = `WAIT_UNIT_CYC
) (
	input wire mclk,
	input wire rst,
	input wire [4:0] addr,
	input wire [15:0] wdata,
	input wire wr,
	input wire rd,
	output reg [15:0] rdata,
	input wire [7:0] termPins,
	input wire termRunPin,
	input wire panelRun,
	input wire commRun,
	input wire [15:0] terminalFreq,
	input wire [15:0] panelFreq,
	input wire [15:0] commFreq,
	input wire [15:0] detFreq,
	input wire voltMatch,
	output reg outEnable,
	output reg [15:0] outFreq,
	output reg scanActive,
	output reg [15:0] currentLimit,
	output reg panelSel,
	output reg terminalSel
);
// ****************************
// states
// ****************************
localparam ST_STOP = 3'd0;
localparam ST_RUN = 3'd1;
localparam ST_COAST = 3'd2;
localparam ST_WAIT = 3'd3;
localparam ST_SCAN = 3'd4;
// ****************************
// functions
// ****************************
function termOn;
	input [63:0] fs;
	input [7:0] t;
	input [7:0] code;
	integer i;
	begin
		termOn = 1'b0;
		for (i = 0; i < 8; i = i + 1) begin
			if (fs[i*8 +: 8] == code && t[i])
				termOn = 1'b1;
		end
	end
endfunction
function [15:0] srcMux;
	input [1:0] sel;
	input [15:0] a;
	input [15:0] b;
	input [15:0] c;
	input [15:0] d;
	begin
		case (sel)
		`SRC_SETREG: srcMux = a;
		`SRC_TERM: srcMux = b;
		`SRC_PANEL: srcMux = c;
		default: srcMux = d;
		endcase
	end
endfunction
// ****************************
// input synchronisers
// ****************************
reg [8:0] pinMeta_r;
reg [8:0] pinSync_r;
always @(posedge mclk or posedge rst) begin
	if (rst) begin
		pinMeta_r <= 9'h000;
		pinSync_r <= 9'h000;
	end else begin
		pinMeta_r <= {termRunPin, termPins};
		pinSync_r <= pinMeta_r;
	end
end
wire [7:0] terms = pinSync_r[7:0];
wire termRun = pinSync_r[8];
// ****************************
// parameter registers
// ****************************
reg [7:0] lockMode_r;
reg [1:0] freqSrc_r;
reg [1:0] runSrc_r;
reg [1:0] restartMode_r;
reg [15:0] retryWait_r;
reg [15:0] thresh_r;
reg [15:0] scanCur_r;
reg [15:0] scanTc_r;
reg [1:0] scanStart_r;
reg duty_r;
reg [15:0] baseFreq_r;
reg [15:0] maxFreq_r;
reg [15:0] setFreq_r;
reg [63:0] fsel_r;
reg lastRejected_r;
reg [2:0] state_r;
reg blocked_r;
wire lockOn = termOn(fsel_r, terms, `FN_LOCK); // RL1
wire panelOvr = termOn(fsel_r, terms, `FN_PANEL); // RL5
wire termOvr = termOn(fsel_r, terms, `FN_TERM); // RL6
wire coast = termOn(fsel_r, terms, `FN_COAST); // RL9
wire driving = (state_r != ST_STOP);
// ****************************
// write protection
// ****************************
reg wrAllowed;
reg valueOk;
wire isLock = (addr == `A_LOCK_MODE);
wire isFreqCmd = (addr == `A_SET_FREQ);
wire isRunChg = isLock || isFreqCmd || (addr == `A_SCAN_CUR) ||
	(addr == `A_SCAN_TC);
always @* begin
	case (lockMode_r)
	`LK_INPUT: wrAllowed = !lockOn || isLock; // RL2
	`LK_INPUT_F: wrAllowed = !lockOn || isLock || isFreqCmd; // RL2
	`LK_ALL: wrAllowed = isLock; // RL3
	`LK_ALL_F: wrAllowed = isLock || isFreqCmd; // RL3
	`LK_RUNCHG: wrAllowed = isRunChg; // RL4
	default: wrAllowed = isLock;
	endcase
end
always @* begin
	case (addr)
	`A_LOCK_MODE: valueOk = (wdata == {8'h00, `LK_INPUT}) ||
		(wdata == {8'h00, `LK_INPUT_F}) ||
		(wdata == {8'h00, `LK_ALL}) ||
		(wdata == {8'h00, `LK_ALL_F}) ||
		(wdata == {8'h00, `LK_RUNCHG});
	`A_RESTART: valueOk = (wdata[15:0] <= {14'h0000, `RS_ACTIVE});
	`A_SCAN_START: valueOk = (wdata <= {14'h0000, `SS_NEW});
	`A_RETRY_WAIT: valueOk = (wdata >= `RETRY_MIN) &&
		(wdata <= `RETRY_MAX);
	`A_THRESH: valueOk = (wdata <= `THRESH_MAX); // RL13
	`A_SCAN_CUR: valueOk = duty_r ? (wdata <= `SCAN_VT_MAX) :
		(wdata <= `SCAN_CT_MAX); // RL18
	`A_STATUS: valueOk = 1'b0;
	`A_OUT_FREQ: valueOk = 1'b0;
	default: valueOk = 1'b1;
	endcase
end
wire wrAccept = wr && wrAllowed && valueOk;
always @(posedge mclk or posedge rst) begin
	if (rst) begin
		lockMode_r <= `LK_INPUT;
		freqSrc_r <= `SRC_SETREG;
		runSrc_r <= `SRC_TERM;
		restartMode_r <= `RS_ZERO;
		retryWait_r <= `RST_RETRY;
		thresh_r <= 16'h0000;
		scanCur_r <= `RST_SCAN_CUR;
		scanTc_r <= `RST_SCAN_TC;
		scanStart_r <= `SS_SHUT;
		duty_r <= 1'b0;
		baseFreq_r <= `RST_BASE_FREQ;
		maxFreq_r <= `RST_MAX_FREQ;
		setFreq_r <= 16'h0000;
		fsel_r <= 64'h0000_0000_0000_0000;
		lastRejected_r <= 1'b0;
	end else if (wr) begin
		lastRejected_r <= !wrAccept;
		if (wrAccept) begin // RL19
			case (addr)
			`A_LOCK_MODE: lockMode_r <= wdata[7:0];
			`A_FREQ_SRC: freqSrc_r <= wdata[1:0];
			`A_RUN_SRC: runSrc_r <= wdata[1:0];
			`A_RESTART: restartMode_r <= wdata[1:0]; // RL12
			`A_RETRY_WAIT: retryWait_r <= wdata;
			`A_THRESH: thresh_r <= wdata;
			`A_SCAN_CUR: scanCur_r <= wdata;
			`A_SCAN_TC: scanTc_r <= wdata;
			`A_SCAN_START: scanStart_r <= wdata[1:0];
			`A_DUTY: duty_r <= wdata[0];
			`A_BASE_FREQ: baseFreq_r <= wdata;
			`A_MAX_FREQ: maxFreq_r <= wdata;
			`A_SET_FREQ: setFreq_r <= wdata;
			default: begin
				if (addr[4:3] == 2'b10)
					fsel_r[addr[2:0]*8 +: 8] <= wdata[7:0]; // RL1
			end
			endcase
		end
	end
end
// ****************************
// command source selection
// ****************************
wire [1:0] runSel = panelOvr ? `SRC_PANEL :
	(termOvr ? `SRC_TERM : runSrc_r); // RL5 RL6
wire [1:0] freqSel = panelOvr ? `SRC_PANEL :
	(termOvr ? `SRC_TERM : freqSrc_r); // RL5 RL6
wire [15:0] runVec = srcMux(runSel, 16'h0000, {15'h0000, termRun},
	{15'h0000, panelRun}, {15'h0000, commRun});
wire runCmd = runVec[0];
wire [15:0] freqRaw = srcMux(freqSel, setFreq_r, terminalFreq,
	panelFreq, commFreq);
wire [15:0] freqCmd = (freqRaw > maxFreq_r) ? maxFreq_r : freqRaw;
reg [1:0] ovrPrev_r;
wire srcChange = ({panelOvr, termOvr} != ovrPrev_r);
wire runOk = runCmd && !blocked_r;
// ****************************
// ramp timing and retry timer
// ****************************
reg [15:0] stepCnt_r;
reg [15:0] scanCnt_r;
wire stepTick = (stepCnt_r == `RAMP_STEP_CYC - 1);
reg timerStart_r;
wire timerDone;
retry_timer #(
	.UNIT_CYC(WAIT_CYC)
) u_timer (
	.mclk(mclk),
	.rst(rst),
	.start(timerStart_r),
	.waitUnits(retryWait_r),
	.done(timerDone)
);
always @(posedge mclk or posedge rst) begin
	if (rst)
		stepCnt_r <= 16'h0000;
	else if (stepTick)
		stepCnt_r <= 16'h0000;
	else
		stepCnt_r <= stepCnt_r + 16'h0001;
end
// ****************************
// drive sequencer
// ****************************
reg [15:0] shutFreq_r;
reg holdTarget_r;
wire [15:0] target = holdTarget_r ? shutFreq_r : freqCmd;
wire lowDet = (detFreq < thresh_r) ||
	(detFreq <= {1'b0, baseFreq_r[15:1]});
reg [15:0] scanFreq;
always @* begin
	case (scanStart_r)
	`SS_SHUT: scanFreq = shutFreq_r; // RL16
	`SS_MAX: scanFreq = maxFreq_r; // RL16
	default: scanFreq = freqCmd; // RL16
	endcase
end
always @(posedge mclk or posedge rst) begin
	if (rst) begin
		state_r <= ST_STOP;
		blocked_r <= 1'b0;
		ovrPrev_r <= 2'b00;
		outFreq <= 16'h0000;
		outEnable <= 1'b0;
		scanActive <= 1'b0;
		shutFreq_r <= 16'h0000;
		holdTarget_r <= 1'b0;
		timerStart_r <= 1'b0;
		scanCnt_r <= 16'h0000;
	end else begin
		ovrPrev_r <= {panelOvr, termOvr};
		timerStart_r <= 1'b0;
		if (srcChange && driving && !coast) begin
			blocked_r <= 1'b1; // RL7 RL8
			state_r <= ST_STOP;
			outEnable <= 1'b0;
			outFreq <= 16'h0000;
			scanActive <= 1'b0;
			holdTarget_r <= 1'b0;
		end else if (coast && state_r != ST_COAST) begin
			if (state_r == ST_RUN)
				shutFreq_r <= outFreq;
			state_r <= ST_COAST; // RL9
			outEnable <= 1'b0;
			scanActive <= 1'b0;
		end else begin
			if (!runCmd)
				blocked_r <= 1'b0; // RL8
			case (state_r)
			ST_STOP: begin
				outEnable <= 1'b0;
				outFreq <= 16'h0000;
				if (runOk) begin
					state_r <= ST_RUN;
					outEnable <= 1'b1;
				end
			end
			ST_RUN: begin
				if (!runOk && outFreq == 16'h0000) begin
					state_r <= ST_STOP;
					outEnable <= 1'b0;
				end else if (stepTick) begin
					if (!runOk)
						outFreq <= outFreq - 16'h0001;
					else if (outFreq < target)
						outFreq <= outFreq + 16'h0001;
					else if (outFreq > target)
						outFreq <= outFreq - 16'h0001;
					else
						holdTarget_r <= 1'b0; // RL17
				end
			end
			ST_COAST: begin
				outEnable <= 1'b0; // RL9
				if (!coast) begin
					if (runSrc_r == `SRC_PANEL) begin
						blocked_r <= 1'b1; // RL11
						state_r <= ST_STOP;
						outFreq <= 16'h0000;
					end else if (restartMode_r == `RS_ZERO) begin
						state_r <= ST_RUN; // RL14
						outFreq <= 16'h0000;
						outEnable <= runOk;
					end else begin
						state_r <= ST_WAIT; // RL10
						timerStart_r <= 1'b1;
					end
				end
			end
			ST_WAIT: begin
				if (!runOk) begin
					state_r <= ST_STOP;
					outFreq <= 16'h0000;
				end else if (timerDone && !timerStart_r) begin
					outEnable <= 1'b1;
					if (restartMode_r == `RS_MATCH) begin
						state_r <= ST_RUN; // RL15
						outFreq <= lowDet ? 16'h0000 : detFreq; // RL13
					end else begin
						state_r <= ST_SCAN;
						outFreq <= scanFreq; // RL16
						scanActive <= 1'b1;
						scanCnt_r <= 16'h0000;
					end
				end
			end
			ST_SCAN: begin
				if (!runOk) begin
					state_r <= ST_STOP;
					outEnable <= 1'b0;
					scanActive <= 1'b0;
				end else if (voltMatch || outFreq == 16'h0000) begin
					state_r <= ST_RUN; // RL17
					scanActive <= 1'b0;
					holdTarget_r <= 1'b1;
				end else if (stepTick) begin
					if (scanCnt_r + 16'h0001 >= scanTc_r) begin
						scanCnt_r <= 16'h0000;
						outFreq <= outFreq - 16'h0001; // RL17
					end else begin
						scanCnt_r <= scanCnt_r + 16'h0001;
					end
				end
			end
			default: begin
				state_r <= ST_STOP;
				outEnable <= 1'b0;
			end
			endcase
		end
	end
end
// ****************************
// current limit and source flags
// ****************************
always @(posedge mclk or posedge rst) begin
	if (rst) begin
		currentLimit <= 16'h0000;
		panelSel <= 1'b0;
		terminalSel <= 1'b0;
	end else begin
		currentLimit <= scanActive ? scanCur_r : 16'h0000; // RL18
		panelSel <= (runSel == `SRC_PANEL);
		terminalSel <= (runSel == `SRC_TERM);
	end
end
// ****************************
// read port
// ****************************
reg [15:0] rdMux;
always @* begin
	case (addr)
	`A_LOCK_MODE: rdMux = {8'h00, lockMode_r};
	`A_FREQ_SRC: rdMux = {14'h0000, freqSrc_r};
	`A_RUN_SRC: rdMux = {14'h0000, runSrc_r};
	`A_RESTART: rdMux = {14'h0000, restartMode_r};
	`A_RETRY_WAIT: rdMux = retryWait_r;
	`A_THRESH: rdMux = thresh_r;
	`A_SCAN_CUR: rdMux = scanCur_r;
	`A_SCAN_TC: rdMux = scanTc_r;
	`A_SCAN_START: rdMux = {14'h0000, scanStart_r};
	`A_DUTY: rdMux = {15'h0000, duty_r};
	`A_BASE_FREQ: rdMux = baseFreq_r;
	`A_MAX_FREQ: rdMux = maxFreq_r;
	`A_SET_FREQ: rdMux = setFreq_r;
	`A_STATUS: rdMux = {5'h00, coast, lastRejected_r, termOvr,
		panelOvr, lockOn, blocked_r, scanActive, outEnable,
		state_r};
	`A_OUT_FREQ: rdMux = outFreq;
	default: begin
		if (addr[4:3] == 2'b10)
			rdMux = {8'h00, fsel_r[addr[2:0]*8 +: 8]};
		else
			rdMux = 16'h0000;
	end
	endcase
end
always @(posedge mclk or posedge rst) begin
	if (rst)
		rdata <= 16'h0000;
	else if (rd)
		rdata <= rdMux;
	else
		rdata <= 16'h0000;
end
endmodule
`default_nettype wire

/* bench/drive_ctrl_properties.sv */
`timescale 1ns/1ns
`default_nettype none
// ********
// port checks
// ********
module drive_ctrl_checker #(
	parameter WAIT_CYC = 10
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [4:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [15:0] rdata,
	input wire logic [7:0] termPins,
	input wire logic voltMatch,
	input wire logic outEnable,
	input wire logic [15:0] outFreq,
	input wire logic scanActive,
	input wire logic [15:0] currentLimit,
	input wire logic panelSel,
	input wire logic terminalSel
);
	logic [7:0] coastMask_r;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// terminals given the coast function
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			coastMask_r <= 8'h00;
		end else if (wr && addr[4:3] == 2'b10) begin
			coastMask_r[addr[2:0]] <= wdata == 16'h000b;
		end
	end
	property p_rd_idle; !$past(rd) |-> rdata == 16'h0000; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("stale read data");
	property p_cur_max; currentLimit <= 16'h00c8; endproperty
	a_cur_max: assert property (p_cur_max) else $error("current high");
	property p_cur_idle;
		!$past(scanActive) |-> currentLimit == 16'h0000; endproperty
	a_cur_idle: assert property (p_cur_idle) else $error("current idle");
	property p_scan_out; scanActive |-> outEnable; endproperty
	a_scan_out: assert property (p_scan_out) else $error("scan no drive");
	property p_sel_excl; !(panelSel && terminalSel); endproperty
	a_sel_excl: assert property (p_sel_excl) else $error("src clash");
	property p_src_stop; $past(outEnable) && (panelSel != $past(panelSel) ||
		terminalSel != $past(terminalSel)) |-> ##[0:3] !outEnable; endproperty
	a_src_stop: assert property (p_src_stop) else $error("switch no stop");
	property p_coast_off; (|(termPins & coastMask_r)) [*5] |-> !outEnable;
	endproperty
	a_coast_off: assert property (p_coast_off) else $error("coast output");
	property p_scan_exit; scanActive && voltMatch |-> ##[1:3] !scanActive;
	endproperty
	a_scan_exit: assert property (p_scan_exit) else $error("scan kept");
	property p_ramp; outEnable && $past(outEnable) && $past(outEnable, 2) &&
		!scanActive && !$past(scanActive) |-> outFreq == $past(outFreq) ||
		outFreq == $past(outFreq) + 16'h0001 ||
		outFreq + 16'h0001 == $past(outFreq); endproperty
	a_ramp: assert property (p_ramp) else $error("frequency jump");
	c_scan: cover property ($rose(scanActive));
	c_src: cover property ($fell(outEnable) && panelSel);
	c_match: cover property (scanActive && voltMatch);
endmodule
bind drive_ctrl drive_ctrl_checker #(.WAIT_CYC(WAIT_CYC))
	drive_ctrl_checker_inst (
	.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
	.rdata(rdata), .termPins(termPins), .voltMatch(voltMatch),
	.outEnable(outEnable), .outFreq(outFreq), .scanActive(scanActive),
	.currentLimit(currentLimit), .panelSel(panelSel),
	.terminalSel(terminalSel));
`default_nettype wire

/* bench/control_panel_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ********
// terminals and panel
// ********
module control_panel_model (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [4:0] ctl,
	input wire logic [15:0] matchLevel,
	input wire logic outEnable,
	input wire logic [15:0] outFreq,
	output logic [7:0] termPins,
	output logic termRunPin,
	output logic panelRun,
	output logic commRun,
	output logic voltMatch
);
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			termPins <= 8'h00;
			termRunPin <= 1'b0;
			panelRun <= 1'b0;
			commRun <= 1'b0;
			voltMatch <= 1'b0;
		end else begin
			termPins <= {4'h0, ctl[3:0]};
			termRunPin <= ctl[4];
			panelRun <= ctl[4];
			commRun <= ctl[4];
			voltMatch <= outEnable && outFreq <= matchLevel;
		end
	end
endmodule
`default_nettype wire

/* bench/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
`include "drive_ctrl_defines.vh"
// ********
// drive control bench
// ********
module testbench;
	localparam int WC = 10;
	logic mclk = 0, rst = 1, wr = 0, rd = 0, voltMatch, outEnable, scanActive;
	logic panelSel, terminalSel, termRunPin, panelRun, commRun;
	logic [4:0] addr = 0, ctl = 0;
	logic [7:0] termPins;
	logic [15:0] wdata = 0, rdata, tFreq = 0, pFreq = 0, cFreq = 0, rv, ev;
	logic [15:0] detFreq = 0, matchLevel = 16'h176f, outFreq, currentLimit;
	logic [15:0] sh [0:31];
	logic [7:0] modes [0:4] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h10};
	logic [4:0] tg [0:2] = '{`A_SET_FREQ, `A_RETRY_WAIT, `A_SCAN_TC};
	int num_errors = 0, cmp_count = 0, cyc = 0, n;
	drive_ctrl #(.WAIT_CYC(WC)) drive_ctrl_inst (.mclk(mclk), .rst(rst),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.termPins(termPins), .termRunPin(termRunPin), .panelRun(panelRun),
		.commRun(commRun), .terminalFreq(tFreq), .panelFreq(pFreq),
		.commFreq(cFreq), .detFreq(detFreq), .voltMatch(voltMatch),
		.outEnable(outEnable), .outFreq(outFreq), .scanActive(scanActive),
		.currentLimit(currentLimit), .panelSel(panelSel),
		.terminalSel(terminalSel));
	control_panel_model control_panel_model_inst (.mclk(mclk), .rst(rst),
		.ctl(ctl), .matchLevel(matchLevel), .outEnable(outEnable),
		.outFreq(outFreq), .termPins(termPins), .termRunPin(termRunPin),
		.panelRun(panelRun), .commRun(commRun), .voltMatch(voltMatch));
	initial begin
		forever #50 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			conclude();
		end
	end
	task automatic conclude();
		if (num_errors == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	function automatic bit allowed(input logic [15:0] md, input logic lk,
		input logic [4:0] a);
		if (a == `A_LOCK_MODE) return 1'b1;
		case (md[7:0])
			`LK_INPUT: return !lk;
			`LK_INPUT_F: return !lk || a == `A_SET_FREQ;
			`LK_ALL: return 1'b0;
			`LK_ALL_F: return a == `A_SET_FREQ;
			default: return a == `A_SET_FREQ || a == `A_SCAN_TC;
		endcase
	endfunction
	task automatic tick(input int k);
		repeat (k) @(posedge mclk);
	endtask
	task automatic wreg(input logic [4:0] a, input logic [15:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
		if (allowed(sh[0], ctl[0], a)) sh[a] = d;
	endtask
	task automatic rreg(input logic [4:0] a, output logic [15:0] d);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	task automatic chk(input string s, input logic [15:0] e, g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic chkf(input string s, input logic e, g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %s exp %b got %b", s, e, g);
		end
	endtask
	task automatic waitfor(input bit s, input logic w);
		n = 0;
		while ((s ? scanActive : outEnable) !== w && n < 3000) begin
			@(posedge mclk);
			#1;
			n++;
		end
	endtask
	// stop by a source flip, drop every run command, flip back
	task automatic halt();
		tick(1);
		ctl[1] <= ~ctl[1];
		waitfor(0, 1'b0);
		chkf("srcStop", 1'b1, n < 6);
		tick(1);
		ctl[4] <= 1'b0;
		tick(4);
		ctl[1] <= ~ctl[1];
		tick(4);
	endtask
	initial begin
		void'($urandom(72635));
		sh[0] = 16'h0000;
		tFreq = 16'($urandom_range(100, 5000));
		pFreq = 16'($urandom_range(100, 5000));
		cFreq = 16'($urandom_range(100, 5000));
		tick(16);
		rst <= 1'b0;
		rreg(`A_RETRY_WAIT, rv);
		chk("retryRst", `RST_RETRY, rv);
		wreg(5'h10, 16'h000f);
		wreg(5'h11, 16'h001f);
		wreg(5'h12, 16'h0033);
		wreg(5'h13, 16'h000b);
		wreg(`A_RUN_SRC, 16'h0003);
		wreg(`A_FREQ_SRC, 16'h0003);
		wreg(`A_THRESH, 16'h03e8);
		wreg(`A_SCAN_START, 16'h0001);
		wreg(`A_SET_FREQ, 16'h0010);
		wreg(`A_SCAN_TC, 16'h0001);
		wreg(5'h1f, 16'h1234);
		for (int i = 0; i < 10; i++) begin
			tick(1);
			ctl[0] <= i[0];
			tick(5);
			wreg(`A_LOCK_MODE, {8'h00, modes[i / 2]});
			for (int j = 0; j < 3; j++) begin
				ev = 16'($urandom_range(3, 9));
				wreg(tg[j], ev);
				rreg(tg[j], rv);
				chk("lockWr", sh[tg[j]], rv);
			end
		end
		tick(1);
		ctl[0] <= 1'b0;
		wreg(`A_LOCK_MODE, 16'h0000);
		for (int d = 1; d >= 0; d--) begin
			wreg(`A_DUTY, d[15:0]);
			ev = d ? 16'h0096 : 16'h00c8;
			wreg(`A_SCAN_CUR, ev + 16'h0001);
			rreg(`A_SCAN_CUR, rv);
			chk("curHigh", d ? `RST_SCAN_CUR : 16'h0096, rv);
			rreg(`A_STATUS, rv);
			chkf("rejSet", 1'b1, rv[9]);
			wreg(`A_SCAN_CUR, ev);
			rreg(`A_SCAN_CUR, rv);
			chk("curMax", ev, rv);
			rreg(`A_STATUS, rv);
			chkf("rejClr", 1'b0, rv[9]);
		end
		wreg(`A_RETRY_WAIT, 16'h0003);
		wreg(`A_SCAN_TC, 16'h0001);
		ctl[4] <= 1'b1;
		waitfor(0, 1'b1);
		tick(1);
		ctl[1] <= 1'b1;
		tick(6);
		chkf("panelSel", 1'b1, panelSel);
		chkf("ovrStop", 1'b0, outEnable);
		ctl[4] <= 1'b0;
		tick(4);
		ctl[4] <= 1'b1;
		waitfor(0, 1'b1);
		chkf("panelRun", 1'b1, outEnable);
		halt();
		ctl[1] <= 1'b0;
		ctl[2] <= 1'b1;
		tick(6);
		chkf("termSel", 1'b1, terminalSel);
		ctl[4] <= 1'b1;
		waitfor(0, 1'b1);
		chkf("termRun", 1'b1, outEnable);
		tick(1);
		ctl[2] <= 1'b0;
		tick(6);
		chkf("termStop", 1'b0, outEnable);
		ctl[4] <= 1'b0;
		tick(4);
		for (int m = 0; m < 5; m++) begin
			if (m == 4) wreg(`A_SCAN_START, 16'h0002);
			wreg(`A_RESTART, m > 2 ? 16'(m - 2) : m[15:0]);
			detFreq <= m == 3 ? 16'h01f4 : 16'($urandom_range(3000, 5900));
			ctl[4] <= 1'b1;
			waitfor(0, 1'b1);
			tick(1);
			ctl[3] <= 1'b1;
			tick(30);
			chkf("coastOff", 1'b0, outEnable);
			ctl[3] <= 1'b0;
			waitfor(m == 2 || m == 4, 1'b1);
			if (m == 0) chkf("zeroNow", 1'b1, n < 8);
			else chkf("waitLen", 1'b1, n >= 3 * WC && n < 3 * WC + 15);
			ev = m == 1 ? detFreq : m == 2 ? `RST_MAX_FREQ :
				m == 4 ? cFreq : 16'h0000;
			chk("startFreq", ev, outFreq);
			if (m == 2 || m == 4) begin
				tick(2);
				#1;
				chk("scanCur", 16'h00c8, currentLimit);
				waitfor(1, 1'b0);
				chkf("reaccel", 1'b1, outEnable);
			end
			halt();
		end
		wreg(`A_RUN_SRC, 16'h0002);
		wreg(`A_RESTART, 16'h0000);
		ctl[4] <= 1'b1;
		waitfor(0, 1'b1);
		tick(1);
		ctl[3] <= 1'b1;
		tick(10);
		ctl[3] <= 1'b0;
		tick(40);
		chkf("noAuto", 1'b0, outEnable);
		ctl[4] <= 1'b0;
		tick(4);
		ctl[4] <= 1'b1;
		waitfor(0, 1'b1);
		chkf("newRun", 1'b1, outEnable);
		conclude();
	end
endmodule
`default_nettype wire
